// [design/omp_fault_core.sv]
`timescale 1ns/1ps
`default_nettype none
module omp_fault_core (
    input wire logic  hclk,
    input wire logic  hresetn,
    omp_fault_if.core fif
);
    import omp_pkg::*;

    logic uv_lat_ff;
    logic ov_lat_ff;
    logic oc_lat_ff;
    logic ls_force_ff;
    logic nxt_uv_lat;
    logic nxt_ov_lat;
    logic nxt_oc_lat;
    logic nxt_ls_force;

    ////////////////////////////////////////////////////////////////////////
    // Fault latches clear only on power-up reset; the low-side force clears when the sense falls below half
    always_comb
    begin
        nxt_uv_lat   = uv_lat_ff | (fif.uv_cmp & fif.uv_arm);
        nxt_ov_lat   = ov_lat_ff | fif.ov_cmp;
        nxt_oc_lat   = oc_lat_ff | fif.oc_trip;
        nxt_ls_force = ls_force_ff;
        if (fif.ov_cmp)
        begin
            nxt_ls_force = 1'b1;
        end
        else if (fif.half_cmp)
        begin
            nxt_ls_force = 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            uv_lat_ff   <= 1'b0;
            ov_lat_ff   <= 1'b0;
            oc_lat_ff   <= 1'b0;
            ls_force_ff <= 1'b0;
        end
        else
        begin
            uv_lat_ff   <= nxt_uv_lat;
            ov_lat_ff   <= nxt_ov_lat;
            oc_lat_ff   <= nxt_oc_lat;
            ls_force_ff <= nxt_ls_force;
        end
    end

    assign fif.uv_lat   = uv_lat_ff;
    assign fif.ov_lat   = ov_lat_ff;
    assign fif.oc_lat   = oc_lat_ff;
    assign fif.ls_force = ls_force_ff;
endmodule
`default_nettype wire

// [design/omp_fault_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface omp_fault_if;
    logic uv_cmp;
    logic ov_cmp;
    logic half_cmp;
    logic oc_trip;
    logic uv_arm;
    logic uv_lat;
    logic ov_lat;
    logic oc_lat;
    logic ls_force;

    modport core (
        input  uv_cmp,
        input  ov_cmp,
        input  half_cmp,
        input  oc_trip,
        input  uv_arm,
        output uv_lat,
        output ov_lat,
        output oc_lat,
        output ls_force
    );

    modport ctrl (
        output uv_cmp,
        output ov_cmp,
        output half_cmp,
        output oc_trip,
        output uv_arm,
        input  uv_lat,
        input  ov_lat,
        input  oc_lat,
        input  ls_force
    );
endinterface
`default_nettype wire

// [design/omp_pkg.sv]
// Operation
// - Leaving the power-good window drops power-good while switching and regulation continue.
// - Power-good rises only after soft-start has finished.
// - An under-voltage turns both gates off and stays latched until the supply is cycled; the code latches it only in PH_RUN, after soft-start.
// - An over-voltage (about 1 V) forces the high-side gate off and the low-side gate on.
// - In an over-voltage response the low-side gate is released once the sense falls below 0.4 V.
// - An over-voltage latches the fault and stops normal switching until the supply is cycled.
// - In any latched fault the low-side gate still turns on whenever over-voltage recurs.
// - A floating sense input, pulled high by 100 nA, reads as over-voltage and latches low-side on.
// - Protection may turn the low-side gate on even while start-up masks it.
// - An over-current trip latches both gates off, overrides soft-start, cleared by power cycle.
package omp_pkg;

    localparam int          AW          = 12;
    localparam logic [11:0] OFS_CTRL    = 12'h000;
    localparam logic [11:0] OFS_STATUS  = 12'h004;
    localparam logic [11:0] OFS_IRQ_ST  = 12'h008;
    localparam logic [11:0] OFS_IRQ_CLR = 12'h00c;
    localparam logic [11:0] OFS_IRQ_EN  = 12'h010;

    localparam int          CTRL_W      = 2;
    localparam int          CTRL_EN     = 0;
    localparam int          CTRL_LOW_SIDE_HOLD_START = 1;
    localparam logic [1:0]  CTRL_RESET  = 2'h3;

    localparam int          IRQ_W       = 6;
    localparam int          IRQ_UV      = 0;
    localparam int          IRQ_OV      = 1;
    localparam int          IRQ_OC      = 2;
    localparam int          IRQ_PG_RISE = 3;
    localparam int          IRQ_PG_FALL = 4;
    localparam int          IRQ_SS_DONE = 5;
    localparam logic [5:0]  IRQ_EN_RESET = 6'h00;

    localparam int          STATUS_W    = 14;

    typedef enum logic [1:0] {
        PH_SOFT_START = 2'b00,
        PH_RUN        = 2'b01,
        PH_FAULT      = 2'b10
    } omp_phase_t;

endpackage

// [design/omp_top.sv]
// The AHB-Lite interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module omp_top (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        output_sense_in_window,
    input  wire logic        output_sense_below_uv,
    input  wire logic        output_sense_above_ov,
    input  wire logic        output_sense_below_half,
    input  wire logic        soft_start_done_in,
    input  wire logic        overcurrent_trip_in,
    input  wire logic        pwm_in,
    output logic             power_good_out,
    output logic             high_side_gate,
    output logic             low_side_gate,
    output logic             irq_out
);
    import omp_pkg::*;

    omp_fault_if fif ();

    omp_fault_core u_core (
        .hclk    (hclk),
        .hresetn (hresetn),
        .fif     (fif)
    );

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    logic [AW-1:0]     addr_ff;
    logic              wr_ff;
    logic              act_ff;
    logic [31:0]       hrdata_ff;
    logic [CTRL_W-1:0] ctrl_ff;
    logic [IRQ_W-1:0]  irq_en_ff;
    logic [IRQ_W-1:0]  irq_st_ff;
    logic              irq_ff;
    omp_phase_t        phase_ff;
    logic              hs_seen_ff;
    logic              pg_ff;
    logic              hs_ff;
    logic              ls_ff;

    logic [AW-1:0]     nxt_addr;
    logic              nxt_wr;
    logic              nxt_act;
    logic [31:0]       nxt_hrdata;
    logic [CTRL_W-1:0] nxt_ctrl;
    logic [IRQ_W-1:0]  nxt_irq_en;
    logic [IRQ_W-1:0]  nxt_irq_st;
    logic              nxt_irq;
    omp_phase_t        nxt_phase;
    logic              nxt_hs_seen;
    logic              nxt_pg;
    logic              nxt_hs;
    logic              nxt_ls;

    logic              addr_take;
    logic              wr_ctrl;
    logic              wr_clr;
    logic              wr_en;
    logic              fault;
    logic              low_side_hold_start_mask;
    logic [IRQ_W-1:0]  irq_evt;
    logic [IRQ_W-1:0]  irq_clr;
    logic [STATUS_W-1:0] status;

    ////////////////////////////////////////////////////////////////////////
    // Comparator results into the fault latches

    assign fif.uv_cmp   = output_sense_below_uv;
    assign fif.ov_cmp   = output_sense_above_ov;
    assign fif.half_cmp = output_sense_below_half;
    assign fif.oc_trip  = overcurrent_trip_in;
    assign fif.uv_arm   = (phase_ff == PH_RUN);

    assign fault = fif.uv_lat | fif.ov_lat | fif.oc_lat;

    ////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave, zero wait states, always OKAY

    assign addr_take = hsel & htrans[1] & hready;
    assign wr_ctrl   = act_ff & wr_ff & (addr_ff == OFS_CTRL);
    assign wr_clr    = act_ff & wr_ff & (addr_ff == OFS_IRQ_CLR);
    assign wr_en     = act_ff & wr_ff & (addr_ff == OFS_IRQ_EN);

    always_comb
    begin
        nxt_act  = addr_take;
        nxt_wr   = addr_take & hwrite;
        nxt_addr = addr_take ? haddr[AW-1:0] : addr_ff;
        nxt_ctrl = wr_ctrl ? hwdata[CTRL_W-1:0] : ctrl_ff;
        nxt_irq_en = wr_en ? hwdata[IRQ_W-1:0] : irq_en_ff;
    end

    ////////////////////////////////////////////////////////////////////////
    // Start-up phase and low-side masking during soft-start

    assign low_side_hold_start_mask = ctrl_ff[CTRL_LOW_SIDE_HOLD_START] & (phase_ff == PH_SOFT_START) & ~hs_seen_ff;

    always_comb
    begin
        nxt_phase   = phase_ff;
        nxt_hs_seen = hs_seen_ff | hs_ff;
        case (phase_ff)
            PH_SOFT_START:
            begin
                if (fault)
                begin
                    nxt_phase = PH_FAULT;
                end
                else if (soft_start_done_in)
                begin
                    nxt_phase = PH_RUN;
                end
            end
            PH_RUN:
            begin
                if (fault)
                begin
                    nxt_phase = PH_FAULT;
                end
            end
            PH_FAULT:
            begin
                nxt_phase = PH_FAULT;
            end
            default:
            begin
                nxt_phase = PH_FAULT;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Gate enables and power-good

    always_comb
    begin
        // High side off under any fault or over-voltage
        nxt_hs = ctrl_ff[CTRL_EN] & pwm_in & ~fault & ~fif.ls_force
               & ~output_sense_above_ov & (phase_ff != PH_FAULT);
        // Protection bypasses the start-up mask and any latch
        nxt_ls = fif.ls_force | output_sense_above_ov
               | (ctrl_ff[CTRL_EN] & ~pwm_in & ~fault & ~low_side_hold_start_mask
                  & (phase_ff != PH_FAULT));
        nxt_pg = ctrl_ff[CTRL_EN] & (phase_ff == PH_RUN) & ~fault
               & output_sense_in_window;
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupts: sticky status, set wins over clear

    always_comb
    begin
        irq_evt = '0;
        irq_evt[IRQ_UV]      = fif.uv_lat;
        irq_evt[IRQ_OV]      = fif.ov_lat;
        irq_evt[IRQ_OC]      = fif.oc_lat;
        irq_evt[IRQ_PG_RISE] = nxt_pg & ~pg_ff;
        irq_evt[IRQ_PG_FALL] = ~nxt_pg & pg_ff;
        irq_evt[IRQ_SS_DONE] = (phase_ff == PH_SOFT_START) & (nxt_phase == PH_RUN);
        irq_clr    = wr_clr ? hwdata[IRQ_W-1:0] : '0;
        nxt_irq_st = (irq_st_ff & ~irq_clr) | irq_evt;
        nxt_irq    = |(nxt_irq_st & nxt_irq_en);
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data, taken from next values so back-to-back reads see writes

    always_comb
    begin
        status = '0;
        status[0]  = output_sense_in_window;
        status[1]  = output_sense_below_uv;
        status[2]  = output_sense_above_ov;
        status[3]  = output_sense_below_half;
        status[4]  = soft_start_done_in;
        status[5]  = fif.uv_lat;
        status[6]  = fif.ov_lat;
        status[7]  = fif.oc_lat;
        status[8]  = fif.ls_force;
        status[9]  = pg_ff;
        status[10] = hs_ff;
        status[11] = ls_ff;
        status[13:12] = phase_ff;
        nxt_hrdata = '0;
        if (addr_take & ~hwrite)
        begin
            case (haddr[AW-1:0])
                OFS_CTRL:   nxt_hrdata[CTRL_W-1:0]   = nxt_ctrl;
                OFS_STATUS: nxt_hrdata[STATUS_W-1:0] = status;
                OFS_IRQ_ST: nxt_hrdata[IRQ_W-1:0]    = nxt_irq_st;
                OFS_IRQ_EN: nxt_hrdata[IRQ_W-1:0]    = nxt_irq_en;
                default:    nxt_hrdata = '0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            addr_ff    <= '0;
            wr_ff      <= 1'b0;
            act_ff     <= 1'b0;
            hrdata_ff  <= '0;
            ctrl_ff    <= CTRL_RESET;
            irq_en_ff  <= IRQ_EN_RESET;
            irq_st_ff  <= '0;
            irq_ff     <= 1'b0;
            phase_ff   <= PH_SOFT_START;
            hs_seen_ff <= 1'b0;
            pg_ff      <= 1'b0;
            hs_ff      <= 1'b0;
            ls_ff      <= 1'b0;
        end
        else
        begin
            addr_ff    <= nxt_addr;
            wr_ff      <= nxt_wr;
            act_ff     <= nxt_act;
            hrdata_ff  <= nxt_hrdata;
            ctrl_ff    <= nxt_ctrl;
            irq_en_ff  <= nxt_irq_en;
            irq_st_ff  <= nxt_irq_st;
            irq_ff     <= nxt_irq;
            phase_ff   <= nxt_phase;
            hs_seen_ff <= nxt_hs_seen;
            pg_ff      <= nxt_pg;
            hs_ff      <= nxt_hs;
            ls_ff      <= nxt_ls;
        end
    end

    assign hreadyout      = 1'b1;
    assign hresp          = 1'b0;
    assign hrdata         = hrdata_ff;
    assign power_good_out = pg_ff;
    assign high_side_gate = hs_ff;
    assign low_side_gate  = ls_ff;
    assign irq_out        = irq_ff;
endmodule
`default_nettype wire

// [verification/omp_load_model.sv]
`timescale 1ns/1ps
`default_nettype none
module omp_load_model #(
    parameter int UV_MV  = 600,
    parameter int WIN_LO = 720,
    parameter int WIN_HI = 880
) (
    input  wire logic [11:0] set_mv,
    input  wire logic        floating,
    output logic             win,
    output logic             uv,
    output logic             ov,
    output logic             half
);
    logic [11:0] v;
    assign v    = floating ? 12'hfff : set_mv;
    assign ov   = v > 12'd1000;
    assign half = v < 12'd400;
    assign uv   = v < 12'(UV_MV);
    assign win  = (v >= 12'(WIN_LO)) && (v <= 12'(WIN_HI));
endmodule
`default_nettype wire

// [verification/omp_top_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module omp_top_chk (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic output_sense_in_window,
    input wire logic output_sense_below_uv,
    input wire logic output_sense_above_ov,
    input wire logic output_sense_below_half,
    input wire logic soft_start_done_in,
    input wire logic overcurrent_trip_in,
    input wire logic power_good_out,
    input wire logic high_side_gate,
    input wire logic low_side_gate
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_ov_hs; output_sense_above_ov |=> !high_side_gate; endproperty
    a_ov_hs: assert property (p_ov_hs) else $error("hs on in overvoltage");
    property p_ov_ls; output_sense_above_ov |=> low_side_gate; endproperty
    a_ov_ls: assert property (p_ov_ls) else $error("ls off in overvoltage");
    property p_pg_ss; $rose(power_good_out) |-> $past(soft_start_done_in); endproperty
    a_pg_ss: assert property (p_pg_ss) else $error("pg before soft start end");
    property p_pg_win; !output_sense_in_window |=> !power_good_out; endproperty
    a_pg_win: assert property (p_pg_win) else $error("pg outside window");
    property p_uv;
        output_sense_below_uv && power_good_out |-> ##2 !high_side_gate [*4];
    endproperty
    a_uv: assert property (p_uv) else $error("hs on after undervoltage");
    property p_oc; overcurrent_trip_in |-> ##2 (!high_side_gate && !power_good_out) [*4];
    endproperty
    a_oc: assert property (p_oc) else $error("gate or pg on after trip");
    property p_ov_latch; output_sense_above_ov |-> ##2 (!high_side_gate && !power_good_out) [*4];
    endproperty
    a_ov_latch: assert property (p_ov_latch) else $error("switching after ov");
    property p_ls_rel;
        output_sense_above_ov ##1 (!output_sense_above_ov && output_sense_below_half) [*2]
            |=> !low_side_gate;
    endproperty
    a_ls_rel: assert property (p_ls_rel) else $error("ls held below half");
endmodule
bind omp_top omp_top_chk i_chk (.hclk, .hresetn, .output_sense_in_window,
    .output_sense_below_uv, .output_sense_above_ov, .output_sense_below_half,
    .soft_start_done_in, .overcurrent_trip_in, .power_good_out, .high_side_gate,
    .low_side_gate);
`default_nettype wire

// [verification/tb_omp_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_omp_top;
    import omp_pkg::*;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, ss = 0, oc = 0, pwm = 0, flt = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
    logic [1:0]  htrans = 0;
    logic [11:0] mv = 12'd800;
    logic hreadyout, hresp, pg, hs, ls, irq, win, uv, ov, half;
    int mismatches = 0, tests_run = 0, cyc = 0;
    always #2.5 hclk = ~hclk;
    omp_top i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .output_sense_in_window(win),
        .output_sense_below_uv(uv), .output_sense_above_ov(ov), .output_sense_below_half(half),
        .soft_start_done_in(ss), .overcurrent_trip_in(oc), .pwm_in(pwm), .power_good_out(pg),
        .high_side_gate(hs), .low_side_gate(ls), .irq_out(irq));
    omp_load_model i_load (.set_mv(mv), .floating(flt), .win, .uv, .ov, .half);
    ////////////////////////////////////////////////////////////////////////////////
    task end_of_test;
        $display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge hclk)
    begin
        cyc++;
        if (cyc > 3000)
        begin
            mismatches++;
            end_of_test;
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task g(input logic [2:0] e);
        chk({29'h0, pg, hs, ls}, {29'h0, e});
    endtask
    task bus(input logic w, input logic [11:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel   <= 1;
        htrans <= 2'b10;
        haddr  <= {20'h0, a};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        chk({31'h0, hresp}, 32'h0);
    endtask
    task sv(input logic [11:0] v);
        @(posedge hclk);
        mv <= v;
        repeat (4) @(posedge hclk);
        #1;
    endtask
    task power_up(input logic done, input logic p);
        @(posedge hclk);
        hresetn <= 0;
        ss      <= 0;
        oc      <= 0;
        flt     <= 0;
        mv      <= 12'd800;
        pwm     <= p;
        repeat (10) @(posedge hclk);
        hresetn <= 1;
        @(posedge hclk);
        ss <= done;
        repeat (5) @(posedge hclk);
        #1;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task t_start;
        power_up(0, 1);
        g(3'b010);
        bus(0, OFS_CTRL, 0);
        chk(rd, 32'h3);
        bus(0, 12'h100, 0);
        chk(rd, 32'h0);
        bus(1, OFS_IRQ_EN, 32'h3f);
        bus(0, OFS_IRQ_EN, 0);
        chk(rd, 32'h3f);
        bus(1, OFS_IRQ_EN, 32'h08);
        @(posedge hclk);
        ss <= 1;
        repeat (5) @(posedge hclk);
        #1;
        chk(pg, 1);
        chk(hs, 1);
        chk(irq, 1);
        bus(0, OFS_IRQ_ST, 0);
        chk(rd, 32'h28);
        bus(1, OFS_IRQ_CLR, 32'h08);
        repeat (3) @(posedge hclk);
        #1;
        chk(irq, 0);
        $display("t_start done");
    endtask
    task t_window;
        sv(12'd900);
        g(3'b010);
        sv(12'd800);
        g(3'b110);
        @(posedge hclk);
        pwm <= 0;
        repeat (3) @(posedge hclk);
        #1;
        g(3'b101);
        bus(1, OFS_CTRL, 32'h0);
        bus(0, OFS_CTRL, 0);
        chk(rd, 32'h0);
        #1;
        g(3'b000);
        bus(1, OFS_CTRL, 32'h3);
        @(posedge hclk);
        pwm <= 1;
        repeat (3) @(posedge hclk);
        #1;
        g(3'b110);
        bus(0, OFS_IRQ_ST, 0);
        chk(rd, 32'h38);
        $display("t_window done");
    endtask
    task t_ov;
        sv(12'd1100);
        g(3'b001);
        sv(12'd600);
        g(3'b001);
        sv(12'd300);
        g(3'b000);
        sv(12'd800);
        g(3'b000);
        sv(12'd1100);
        g(3'b001);
        sv(12'd300);
        g(3'b000);
        $display("t_ov done");
    endtask
    task t_uv;
        power_up(1, 1);
        g(3'b110);
        sv(12'd500);
        g(3'b000);
        sv(12'd800);
        g(3'b000);
        sv(12'd1100);
        g(3'b001);
        $display("t_uv done");
    endtask
    task t_oc;
        power_up(0, 1);
        @(posedge hclk);
        oc <= 1;
        @(posedge hclk);
        oc <= 0;
        ss <= 1;
        sv(12'd800);
        g(3'b000);
        @(posedge hclk);
        flt <= 1;
        repeat (3) @(posedge hclk);
        #1;
        g(3'b001);
        $display("t_oc done");
    endtask
    task t_float;
        power_up(0, 0);
        g(3'b000);
        @(posedge hclk);
        flt <= 1;
        repeat (3) @(posedge hclk);
        #1;
        g(3'b001);
        @(posedge hclk);
        flt <= 0;
        repeat (3) @(posedge hclk);
        #1;
        g(3'b001);
        $display("t_float done");
    endtask
    initial
    begin
        t_start;
        t_window;
        t_ov;
        t_uv;
        t_oc;
        t_float;
        end_of_test;
    end
endmodule
`default_nettype wire
